// ==== hw/rfs_map.svh ====
// Register map, field positions and timing counts of the synthesiser control block
`ifndef RFS_MAP_SVH
`define RFS_MAP_SVH
`define RFS_A_GENCTL     8'h31
`define RFS_A_PLLCON     8'h34
`define RFS_A_LOCKDET    8'h36
`define RFS_A_FLCK       8'h37
`define RFS_A_RDIV       8'h38
`define RFS_A_IDIV       8'h39
`define RFS_A_FLOW       8'h3a
`define RFS_A_FHIGH      8'h3b
`define RFS_A_LOCTL      8'h3f
`define RFS_A_CALCTL     8'h50
`define RFS_A_BIASWR     8'h51
`define RFS_A_BIASTIME   8'h52
`define RFS_A_OSCWR      8'h53
`define RFS_A_OPENCNT    8'h54
`define RFS_A_SETTLE     8'h55
`define RFS_A_STARTUP    8'h56
`define RFS_A_BIASRD     8'h5b
`define RFS_A_OSCRD      8'h5c
`define RFS_A_CALSTAT    8'h5e
`define RFS_A_FLAGS      8'hc4
`define RFS_A_IRQMASK    8'hc5
`define RFS_B_RF_EN      2
`define RFS_B_FAST_EN    12
`define RFS_B_BITS24N    9
`define RFS_B_CAL_BIAS   0
`define RFS_B_CAL_OSC    1
`define RFS_B_SLOW       6
`define RFS_B_FAST       5
`define RFS_B_CALDONE    0
`define RFS_MOD_MASH     4'hd
`define RFS_RST_REG      16'h0000
`define RFS_CLK_MHZ      40
`define RFS_UNIT8_US     8
`define RFS_FASTLOCK_US  16'h0040
`define RFS_HOST_A_LCL_CMD  2'h0
`define RFS_HOST_A_LCL_ADR  2'h1
`define RFS_HOST_A_LCL_DAT  2'h2
`define RFS_HOST_A_LCL_STAT 2'h3
`endif

// ==== hw/rfs_pkg.sv ====
// Types shared by both ends of the synthesiser control link
`default_nettype none
package rfs_pkg;
	typedef enum logic [2:0] {
		RFS_IDLE  = 3'b000,
		RFS_BIAS  = 3'b001,
		RFS_START = 3'b011,
		RFS_OPEN  = 3'b010,
		RFS_SETL  = 3'b110,
		RFS_CLOSE = 3'b111
	} rfs_cal_t;
	typedef enum logic [1:0] {
		RFS_H_IDLE = 2'b00,
		RFS_H_REQ  = 2'b01,
		RFS_H_WAIT = 2'b11
	} rfs_host_t;
endpackage : rfs_pkg
`default_nettype wire

// ==== hw/rfs_link_if.sv ====
// Register link between the host controller and the synthesiser device
`default_nettype none
interface rfs_link_if;
	logic [7:0]  addr;
	logic [15:0] wdata;
	logic        wr;
	logic        rd;
	logic [15:0] rdata;
	logic        irq;
	modport host (output addr, output wdata, output wr, output rd, input rdata, input irq);
	modport dev  (input addr, input wdata, input wr, input rd, output rdata, output irq);
endinterface : rfs_link_if
`default_nettype wire

// ==== hw/rfs_device.sv ====
// Synthesiser device: divider load order, fast lock and oscillator calibration
//
// The plain strobed port is this design's own decision.
`default_nettype none
`include "rfs_map.svh"
module rfs_device
	import rfs_pkg::*;
(
	input  wire logic        sys_clk_in,
	input  wire logic        rstn_in,
	rfs_link_if.dev          link,
	input  wire logic        drift_slow_in,
	input  wire logic        drift_fast_in,
	output logic             synth_pwr_out,
	output logic             ref_amp_out,
	output logic             cp_enable_out,
	output logic             fast_lock_out,
	output logic             frac_mode_out,
	output logic             bits24_out,
	output logic [15:0]      int_div_out,
	output logic [23:0]      frac_out,
	output logic [8:0]       osc_code_out,
	output logic [4:0]       bias_code_out
);
	logic [15:0] genctl_q, genctl_d, con_q, con_d, lock_q, lock_d, flck_q, flck_d;
	logic [15:0] rdiv_q, rdiv_d;
	logic [15:0] idiv_q, idiv_d, fhi_q, fhi_d, flo_q, flo_d, lo_q, lo_d, cal_q, cal_d;
	logic [15:0] bwr_q, bwr_d, btime_q, btime_d, owr_q, owr_d, ocnt_q, ocnt_d;
	logic [15:0] setl_q, setl_d, start_q, start_d, mask_q, mask_d;
	logic [15:0] ai_q, ai_d, rdata_q, rdata_d;
	logic [23:0] af_q, af_d;
	logic [8:0]  osc_q, osc_d;
	logic [4:0]  bias_q, bias_d;
	logic        loaded_q, loaded_d, apply;
	logic [15:0] fl_cnt_q, fl_cnt_d;
	logic [1:0]  st_q, st_d;
	logic        irq_q, irq_d;
	rfs_cal_t    cs_q, cs_d;
	logic [23:0] cnt_q, cnt_d;
	logic [7:0]  us_q, us_d;
	logic [2:0]  rep_q, rep_d;
	logic        osc_pend_q, osc_pend_d, busy;
	logic [1:0]  ss_q, sf_q;
	logic        ssm_q, sfm_q;
	logic        usp, frac_mode, mode24;

	assign usp       = (us_q == 8'(`RFS_CLK_MHZ - 1));
	assign frac_mode = (con_q[14:11] == `RFS_MOD_MASH);
	assign mode24    = frac_mode && !con_q[`RFS_B_BITS24N];
	assign busy      = (cs_q != RFS_IDLE);

	// Ratio applies on the write that closes the sequence for the mode
	always_comb begin
		apply = 1'b0;
		if (link.wr && genctl_q[`RFS_B_RF_EN]) begin
			if (!frac_mode)
				apply = (link.addr == `RFS_A_IDIV);
			else
				apply = (link.addr == `RFS_A_FLOW);
		end
	end

	always_comb begin
		genctl_d = genctl_q; con_d = con_q; lock_d = lock_q; flck_d = flck_q; rdiv_d = rdiv_q;
		idiv_d = idiv_q; fhi_d = fhi_q; flo_d = flo_q; lo_d = lo_q; cal_d = cal_q;
		bwr_d = bwr_q; btime_d = btime_q; owr_d = owr_q; ocnt_d = ocnt_q;
		setl_d = setl_q; start_d = start_q; mask_d = mask_q;
		ai_d = ai_q; af_d = af_q; osc_d = osc_q; bias_d = bias_q;
		loaded_d = loaded_q; fl_cnt_d = fl_cnt_q; st_d = st_q;
		cs_d = cs_q; cnt_d = cnt_q; rep_d = rep_q; osc_pend_d = osc_pend_q;
		us_d = usp ? 8'h00 : us_q + 8'h01;
		rdata_d = 16'h0000;
		if (link.wr) begin
			case (link.addr)
				`RFS_A_GENCTL:   genctl_d = link.wdata;
				`RFS_A_PLLCON:   con_d = link.wdata;
				`RFS_A_LOCKDET:  lock_d = link.wdata;
				`RFS_A_FLCK:     flck_d = link.wdata;
				`RFS_A_RDIV:     rdiv_d = link.wdata;
				`RFS_A_IDIV:     idiv_d = link.wdata;
				`RFS_A_FHIGH:    fhi_d = link.wdata;
				`RFS_A_FLOW:     flo_d = link.wdata;
				`RFS_A_LOCTL:    lo_d = link.wdata;
				`RFS_A_CALCTL:   cal_d = link.wdata;
				`RFS_A_BIASWR:   bwr_d = link.wdata;
				`RFS_A_BIASTIME: btime_d = link.wdata;
				`RFS_A_OSCWR: begin
					owr_d = link.wdata;
					osc_d = link.wdata[8:0];
				end
				`RFS_A_OPENCNT:  ocnt_d = link.wdata;
				`RFS_A_SETTLE:   setl_d = link.wdata;
				`RFS_A_STARTUP:  start_d = link.wdata;
				`RFS_A_IRQMASK:  mask_d = link.wdata;
				`RFS_A_FLAGS:    st_d = st_q & ~link.wdata[1:0];
				default: ;
			endcase
		end
		if (apply) begin
			ai_d = (link.addr == `RFS_A_FLOW) ? idiv_q : link.wdata;
			if (link.addr == `RFS_A_FLOW)
				af_d = mode24 ? {fhi_q[7:0], link.wdata} : {8'h00, link.wdata};
			loaded_d = 1'b1;
			if (lock_q[`RFS_B_FAST_EN])
				fl_cnt_d = `RFS_FASTLOCK_US;
		end else if (fl_cnt_q != 16'h0000 && usp) begin
			fl_cnt_d = fl_cnt_q - 16'h0001;
		end
		if (!genctl_q[`RFS_B_RF_EN])
			loaded_d = 1'b0;
		// Calibration sequencer; each phase counts in microseconds or reference counts
		case (cs_q)
			RFS_IDLE: begin
				if (cal_q[`RFS_B_CAL_BIAS]) begin
					cs_d = RFS_BIAS;
					rep_d = 3'h0;
					cnt_d = {18'h0, btime_q[5:0]};
					osc_pend_d = cal_q[`RFS_B_CAL_OSC];
					cal_d[1:0] = 2'b00;
				end else if (cal_q[`RFS_B_CAL_OSC]) begin
					cs_d = RFS_START;
					cnt_d = {12'h0, start_q[11:0]};
					cal_d[1:0] = 2'b00;
				end
			end
			RFS_BIAS: if (usp) begin
				if (cnt_q != 24'h0) cnt_d = cnt_q - 24'h1;
				else if (rep_q != 3'h5) begin
					rep_d = rep_q + 3'h1;
					cnt_d = {18'h0, btime_q[5:0]};
				end else begin
					bias_d = bwr_q[4:0] ^ cal_q[12:8];
					st_d[0] = 1'b1;
					if (osc_pend_q) begin
						cs_d = RFS_START;
						cnt_d = {12'h0, start_q[11:0]};
					end else cs_d = RFS_IDLE;
				end
			end
			RFS_START: if (usp) begin
				if (cnt_q != 24'h0) cnt_d = cnt_q - 24'h1;
				else begin
					cs_d = RFS_OPEN;
					cnt_d = 24'(6 * ocnt_q[9:0] * rdiv_q[6:0]);
				end
			end
			RFS_OPEN: begin
				// One reference count per MHz step of reference time
				if (cnt_q >= {16'h0, cal_q[15:8]} && usp) cnt_d = cnt_q - {16'h0, cal_q[15:8]};
				else if (cnt_q < {16'h0, cal_q[15:8]}) begin
					cs_d = RFS_SETL;
					cnt_d = 24'(setl_q[15:8] * `RFS_UNIT8_US);
				end
			end
			RFS_SETL: if (usp) begin
				if (cnt_q != 24'h0) cnt_d = cnt_q - 24'h1;
				else begin
					cs_d = RFS_CLOSE;
					rep_d = 3'h0;
					cnt_d = 24'(setl_q[7:0] * `RFS_UNIT8_US);
				end
			end
			RFS_CLOSE: if (usp) begin
				if (cnt_q != 24'h0) cnt_d = cnt_q - 24'h1;
				else if (rep_q != 3'h3) begin
					rep_d = rep_q + 3'h1;
					cnt_d = 24'(setl_q[7:0] * `RFS_UNIT8_US);
				end else begin
					osc_d = owr_q[8:0];
					st_d[0] = 1'b1;
					cs_d = RFS_IDLE;
				end
			end
			default: cs_d = RFS_IDLE;
		endcase
		// Rising drift edges on either pin set the one sticky bit 1; set wins over clear
		if (ss_q[1] && !ssm_q) st_d[1] = 1'b1;
		if (sf_q[1] && !sfm_q) st_d[1] = 1'b1;
		irq_d = |(st_d & mask_q[1:0]);
		if (link.rd) begin
			case (link.addr)
				`RFS_A_GENCTL:   rdata_d = genctl_q;
				`RFS_A_PLLCON:   rdata_d = con_q;
				`RFS_A_LOCKDET:  rdata_d = lock_q;
				`RFS_A_FLCK:     rdata_d = flck_q;
				`RFS_A_RDIV:     rdata_d = rdiv_q;
				`RFS_A_IDIV:     rdata_d = idiv_q;
				`RFS_A_FHIGH:    rdata_d = fhi_q;
				`RFS_A_FLOW:     rdata_d = flo_q;
				`RFS_A_LOCTL:    rdata_d = lo_q;
				`RFS_A_CALCTL:   rdata_d = cal_q;
				`RFS_A_BIASWR:   rdata_d = bwr_q;
				`RFS_A_BIASTIME: rdata_d = btime_q;
				`RFS_A_OSCWR:    rdata_d = owr_q;
				`RFS_A_OPENCNT:  rdata_d = ocnt_q;
				`RFS_A_SETTLE:   rdata_d = setl_q;
				`RFS_A_STARTUP:  rdata_d = start_q;
				`RFS_A_BIASRD:   rdata_d = {11'h0, bias_q};
				`RFS_A_OSCRD:    rdata_d = {7'h0, osc_q};
				`RFS_A_CALSTAT:  rdata_d = {12'h0, cs_q, busy};
				`RFS_A_FLAGS:    rdata_d = {9'h0, ss_q[1], sf_q[1], 3'h0, st_q};
				`RFS_A_IRQMASK:  rdata_d = mask_q;
				default:         rdata_d = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			genctl_q <= `RFS_RST_REG; con_q <= `RFS_RST_REG; lock_q <= `RFS_RST_REG;
			flck_q <= `RFS_RST_REG; rdiv_q <= `RFS_RST_REG; idiv_q <= `RFS_RST_REG;
			fhi_q <= `RFS_RST_REG; flo_q <= `RFS_RST_REG; lo_q <= `RFS_RST_REG;
			cal_q <= `RFS_RST_REG; bwr_q <= `RFS_RST_REG; btime_q <= `RFS_RST_REG;
			owr_q <= `RFS_RST_REG; ocnt_q <= `RFS_RST_REG; setl_q <= `RFS_RST_REG;
			start_q <= `RFS_RST_REG; mask_q <= `RFS_RST_REG; ai_q <= 16'h0000;
			rdata_q <= 16'h0000; af_q <= 24'h0; osc_q <= 9'h0; bias_q <= 5'h0;
			loaded_q <= 1'b0; fl_cnt_q <= 16'h0; st_q <= 2'b00; irq_q <= 1'b0;
			cs_q <= RFS_IDLE; cnt_q <= 24'h0; us_q <= 8'h0; rep_q <= 3'h0;
			osc_pend_q <= 1'b0;
			ss_q <= 2'b00; sf_q <= 2'b00; ssm_q <= 1'b0; sfm_q <= 1'b0;
		end else begin
			genctl_q <= genctl_d; con_q <= con_d; lock_q <= lock_d; flck_q <= flck_d;
			rdiv_q <= rdiv_d; idiv_q <= idiv_d; fhi_q <= fhi_d; flo_q <= flo_d;
			lo_q <= lo_d; cal_q <= cal_d; bwr_q <= bwr_d; btime_q <= btime_d;
			owr_q <= owr_d; ocnt_q <= ocnt_d; setl_q <= setl_d; start_q <= start_d;
			mask_q <= mask_d; ai_q <= ai_d; rdata_q <= rdata_d; af_q <= af_d;
			osc_q <= osc_d; bias_q <= bias_d; loaded_q <= loaded_d;
			fl_cnt_q <= fl_cnt_d; st_q <= st_d; irq_q <= irq_d; cs_q <= cs_d;
			cnt_q <= cnt_d; us_q <= us_d; rep_q <= rep_d; osc_pend_q <= osc_pend_d;
			// Drift pins are asynchronous; second stage feeds the edge detector
			ss_q <= {ss_q[0], drift_slow_in};
			sf_q <= {sf_q[0], drift_fast_in};
			ssm_q <= ss_q[1];
			sfm_q <= sf_q[1];
		end
	end

	assign link.rdata = rdata_q;
	assign link.irq   = irq_q;

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			synth_pwr_out <= 1'b0; ref_amp_out <= 1'b0; cp_enable_out <= 1'b0;
			fast_lock_out <= 1'b0; frac_mode_out <= 1'b0; bits24_out <= 1'b0;
			int_div_out <= 16'h0; frac_out <= 24'h0; osc_code_out <= 9'h0;
			bias_code_out <= 5'h0;
		end else begin
			synth_pwr_out <= genctl_q[`RFS_B_RF_EN];
			ref_amp_out   <= genctl_q[`RFS_B_RF_EN];
			cp_enable_out <= loaded_q;
			fast_lock_out <= (fl_cnt_q != 16'h0000);
			frac_mode_out <= frac_mode;
			bits24_out    <= mode24;
			int_div_out   <= ai_q;
			frac_out      <= af_q;
			osc_code_out  <= osc_q;
			bias_code_out <= bias_q;
		end
	end
endmodule : rfs_device
`default_nettype wire

// ==== hw/rfs_host.sv ====
// Host controller: turns local commands into single register cycles on the link
`default_nettype none
`include "rfs_map.svh"
module rfs_host
	import rfs_pkg::*;
(
	input  wire logic        sys_clk_in,
	input  wire logic        rstn_in,
	rfs_link_if.host         link,
	input  wire logic [1:0]  cmd_addr_in,
	input  wire logic [15:0] cmd_wdata_in,
	input  wire logic        cmd_wr_in,
	input  wire logic        cmd_rd_in,
	output logic [15:0]      cmd_rdata_out,
	output logic             irq_out
);
	// Local regs: cmd(0) bit0 go, bit1 read; adr(1); dat(2); stat(3) bit0 busy
	logic [7:0]  adr_q, adr_d;
	logic [15:0] dat_q, dat_d, res_q, res_d, crd_q, crd_d;
	logic        wr_q, wr_d, rd_q, rd_d, irq_q;
	rfs_host_t   hs_q, hs_d;

	// order of programming is software's job through this port
	always_comb begin
		adr_d = adr_q; dat_d = dat_q; res_d = res_q; hs_d = hs_q;
		wr_d = 1'b0; rd_d = 1'b0; crd_d = 16'h0000;
		if (cmd_wr_in && hs_q == RFS_H_IDLE) begin
			case (cmd_addr_in)
				`RFS_HOST_A_LCL_ADR: adr_d = cmd_wdata_in[7:0];
				`RFS_HOST_A_LCL_DAT: dat_d = cmd_wdata_in;
				`RFS_HOST_A_LCL_CMD: if (cmd_wdata_in[0]) begin
					hs_d = RFS_H_REQ;
					wr_d = !cmd_wdata_in[1];
					rd_d = cmd_wdata_in[1];
				end
				default: ;
			endcase
		end
		case (hs_q)
			RFS_H_IDLE: ;
			RFS_H_REQ:  hs_d = rd_q ? RFS_H_WAIT : RFS_H_IDLE;
			RFS_H_WAIT: begin
				res_d = link.rdata;
				hs_d = RFS_H_IDLE;
			end
			default: hs_d = RFS_H_IDLE;
		endcase
		if (cmd_rd_in) begin
			case (cmd_addr_in)
				`RFS_HOST_A_LCL_ADR:  crd_d = {8'h00, adr_q};
				`RFS_HOST_A_LCL_DAT:  crd_d = res_q;
				`RFS_HOST_A_LCL_STAT: crd_d = {15'h0, hs_q != RFS_H_IDLE};
				default:              crd_d = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			adr_q <= 8'h00; dat_q <= 16'h0; res_q <= 16'h0; crd_q <= 16'h0;
			wr_q <= 1'b0; rd_q <= 1'b0; irq_q <= 1'b0; hs_q <= RFS_H_IDLE;
		end else begin
			adr_q <= adr_d; dat_q <= dat_d; res_q <= res_d; crd_q <= crd_d;
			wr_q <= wr_d; rd_q <= rd_d; irq_q <= link.irq; hs_q <= hs_d;
		end
	end

	assign link.addr  = adr_q;
	assign link.wdata = dat_q;
	assign link.wr    = wr_q;
	assign link.rd    = rd_q;
	assign cmd_rdata_out = crd_q;
	assign irq_out    = irq_q;
endmodule : rfs_host
`default_nettype wire

// ==== tb/rfs_link_monitor.sv ====
// Assertions on the synthesiser register link and the applied ratio outputs
`default_nettype none
`include "rfs_map.svh"
module rfs_link_monitor (
	input wire logic        sys_clk_in,
	input wire logic        rstn_in,
	input wire logic [7:0]  addr,
	input wire logic [15:0] wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [15:0] rdata,
	input wire logic        cp_enable_out,
	input wire logic        fast_lock_out,
	input wire logic        frac_mode_out,
	input wire logic        bits24_out,
	input wire logic [15:0] int_div_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [11:0] fl_cnt_q;
	logic        ld_w;
	assign ld_w = wr && (addr == `RFS_A_IDIV || addr == `RFS_A_FLOW);
	// Reload on any divider write makes only an upper bound safe
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			fl_cnt_q <= 12'h000;
		end else if (ld_w || !fast_lock_out) begin
			fl_cnt_q <= 12'h000;
		end else begin
			fl_cnt_q <= fl_cnt_q + 12'h001;
		end
	end
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);
	chk_strobe_excl: assert property (!(wr && rd))
		else $error("write and read strobes together");
	chk_rdata_idle: assert property (!rd |=> rdata == 16'h0000)
		else $error("read data without a read");
	chk_cp_source: assert property ($rose(cp_enable_out) |-> $past(ld_w, 2))
		else $error("charge pump enabled without divider load");
	chk_ratio_source: assert property ($changed(int_div_out) |-> $past(ld_w, 2))
		else $error("ratio changed without divider load");
	chk_fast_source: assert property ($rose(fast_lock_out) |-> $past(ld_w, 2))
		else $error("fast lock without ratio apply");
	chk_fast_hold: assert property ($rose(fast_lock_out) |-> fast_lock_out [*8])
		else $error("fast lock pulse too short");
	chk_fast_bound: assert property (fl_cnt_q <= 12'ha0a)
		else $error("fast lock never ends");
	chk_mash_select: assert property (wr && addr == `RFS_A_PLLCON
		&& wdata[14:11] == `RFS_MOD_MASH |-> ##[1:3] frac_mode_out)
		else $error("modulator code not selected");
	chk_res_select: assert property (wr && addr == `RFS_A_PLLCON
		&& wdata[14:11] == `RFS_MOD_MASH && !wdata[9] |-> ##[1:3] bits24_out)
		else $error("24-bit resolution not selected");
	cov_fast: cover property ($rose(fast_lock_out));
	cov_cp: cover property ($rose(cp_enable_out));
	cov_read: cover property (rd ##1 rdata != 16'h0000);
endmodule : rfs_link_monitor
`default_nettype wire

// ==== tb/test_rf_synth_divider_load_and_vco_cal.sv ====
// Bench joining host controller and synthesiser device over the register link
`default_nettype none
`include "rfs_map.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module test_rf_synth_divider_load_and_vco_cal
	import rfs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk_in    = 1'b0;
	logic        rstn_in       = 1'b0;
	logic [1:0]  cmd_addr_in   = 2'h0;
	logic [15:0] cmd_wdata_in  = 16'h0000;
	logic        cmd_wr_in     = 1'b0;
	logic        cmd_rd_in     = 1'b0;
	logic        drift_slow_in = 1'b0;
	logic        drift_fast_in = 1'b0;
	logic [15:0] cmd_rdata_out;
	logic        irq_out;
	logic        synth_pwr_out;
	logic        ref_amp_out;
	logic        cp_enable_out;
	logic        fast_lock_out;
	logic        frac_mode_out;
	logic        bits24_out;
	logic [15:0] int_div_out;
	logic [23:0] frac_out;
	logic [8:0]  osc_code_out;
	logic [4:0]  bias_code_out;
	logic [15:0] q;
	int          mismatches    = 0;
	int          compares      = 0;
	rfs_link_if link ();
	rfs_host rfs_host_i (.sys_clk_in, .rstn_in, .link, .cmd_addr_in, .cmd_wdata_in,
		.cmd_wr_in, .cmd_rd_in, .cmd_rdata_out, .irq_out);
	rfs_device rfs_device_i (.sys_clk_in, .rstn_in, .link, .drift_slow_in, .drift_fast_in,
		.synth_pwr_out, .ref_amp_out, .cp_enable_out, .fast_lock_out, .frac_mode_out,
		.bits24_out, .int_div_out, .frac_out, .osc_code_out, .bias_code_out);
	rfs_link_monitor rfs_link_monitor_i (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
		.addr(link.addr), .wdata(link.wdata), .wr(link.wr), .rd(link.rd),
		.rdata(link.rdata), .cp_enable_out(cp_enable_out), .fast_lock_out(fast_lock_out),
		.frac_mode_out(frac_mode_out), .bits24_out(bits24_out), .int_div_out(int_div_out));
	always #12.5 sys_clk_in = ~sys_clk_in;
	task automatic conclude;
		if (mismatches == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : conclude
	// Leading edge wait keeps the strobe from being driven twice in one step
	task automatic lw(input logic [1:0] a, input logic [15:0] d);
		@(posedge sys_clk_in);
		cmd_addr_in <= a;
		cmd_wdata_in <= d;
		cmd_wr_in <= 1'b1;
		@(posedge sys_clk_in);
		cmd_wr_in <= 1'b0;
	endtask : lw
	task automatic lr(input logic [1:0] a, output logic [15:0] v);
		@(posedge sys_clk_in);
		cmd_addr_in <= a;
		cmd_rd_in <= 1'b1;
		@(posedge sys_clk_in);
		cmd_rd_in <= 1'b0;
		@(posedge sys_clk_in);
		v = cmd_rdata_out;
	endtask : lr
	// One device register cycle through the host; result lands in q
	task automatic acc(input logic [7:0] a, input logic [15:0] d, input logic r);
		logic [15:0] s;
		lw(`RFS_HOST_A_LCL_ADR, {8'h00, a});
		lw(`RFS_HOST_A_LCL_DAT, d);
		lw(`RFS_HOST_A_LCL_CMD, {14'h0000, r, 1'b1});
		s = 16'hffff;
		for (int i = 0; i < 20 && s[0] !== 1'b0; i++) begin
			lr(`RFS_HOST_A_LCL_STAT, s);
		end
		`CHK(s[0], 1'b0)
		lr(`RFS_HOST_A_LCL_DAT, q);
	endtask : acc
	initial begin
		repeat (20000) @(posedge sys_clk_in);
		mismatches++;
		conclude();
	end
	initial begin
		repeat (5) @(posedge sys_clk_in);
		rstn_in <= 1'b1;
		`CHK(cp_enable_out, 1'b0)
		acc(`RFS_A_GENCTL, 16'h0004, 1'b0);
		`CHK({synth_pwr_out, ref_amp_out}, 2'b11)
		`CHK(cp_enable_out, 1'b0)
		acc(`RFS_A_PLLCON, 16'h0000, 1'b0);
		acc(`RFS_A_LOCKDET, 16'h0000, 1'b0);
		acc(`RFS_A_FLCK, 16'h0000, 1'b0);
		acc(`RFS_A_RDIV, 16'h0001, 1'b0);
		acc(`RFS_A_IDIV, 16'h00b8, 1'b0);
		`CHK(int_div_out, 16'h00b8)
		`CHK(cp_enable_out, 1'b1)
		acc(`RFS_A_PLLCON, 16'h6800, 1'b0);
		acc(`RFS_A_LOCKDET, 16'h1000, 1'b0);
		`CHK({frac_mode_out, bits24_out}, 2'b11)
		acc(`RFS_A_IDIV, 16'h00c5, 1'b0);
		`CHK(int_div_out, 16'h00b8)
		acc(`RFS_A_FHIGH, 16'h0098, 1'b0);
		acc(`RFS_A_FLOW, 16'haaab, 1'b0);
		`CHK({int_div_out, frac_out}, 40'h00c598aaab)
		`CHK(fast_lock_out, 1'b1)
		acc(`RFS_A_PLLCON, 16'h6a00, 1'b0);
		`CHK(bits24_out, 1'b0)
		acc(`RFS_A_FLOW, 16'h1234, 1'b0);
		`CHK(frac_out, 24'h001234)
		repeat (2700) @(posedge sys_clk_in);
		`CHK(fast_lock_out, 1'b0)
		// Short steps keep the whole calibration near 60 us
		acc(`RFS_A_BIASWR, 16'h0005, 1'b0);
		acc(`RFS_A_BIASTIME, 16'h0001, 1'b0);
		acc(`RFS_A_OSCWR, 16'h0123, 1'b0);
		acc(`RFS_A_OPENCNT, 16'h0002, 1'b0);
		acc(`RFS_A_SETTLE, 16'h0101, 1'b0);
		acc(`RFS_A_STARTUP, 16'h0002, 1'b0);
		acc(`RFS_A_CALCTL, 16'h2803, 1'b0);
		acc(`RFS_A_CALSTAT, 16'h0000, 1'b1);
		`CHK(q, 16'h0003)
		repeat (1000) @(posedge sys_clk_in);
		acc(`RFS_A_CALSTAT, 16'h0000, 1'b1);
		`CHK(q, 16'h000f)
		repeat (1250) @(posedge sys_clk_in);
		acc(`RFS_A_CALSTAT, 16'h0000, 1'b1);
		`CHK(q[0], 1'b1)
		repeat (200) @(posedge sys_clk_in);
		acc(`RFS_A_CALSTAT, 16'h0000, 1'b1);
		`CHK(q[0], 1'b0)
		// Reference divider only raised once calibration is over
		acc(`RFS_A_RDIV, 16'h0002, 1'b0);
		acc(`RFS_A_RDIV, 16'h0000, 1'b1);
		`CHK(q, 16'h0002)
		acc(`RFS_A_BIASRD, 16'hffff, 1'b0);
		acc(`RFS_A_BIASRD, 16'h0000, 1'b1);
		`CHK(q, 16'h000d)
		`CHK(bias_code_out, 5'h0d)
		acc(`RFS_A_OSCRD, 16'h0000, 1'b1);
		`CHK(q, 16'h0123)
		acc(8'h77, 16'h0000, 1'b1);
		`CHK(q, 16'h0000)
		acc(`RFS_A_OSCWR, 16'h0124, 1'b0);
		`CHK(osc_code_out, 9'h124)
		drift_slow_in <= 1'b1;
		acc(`RFS_A_FLAGS, 16'h0000, 1'b1);
		`CHK(q, 16'h0043)
		drift_slow_in <= 1'b0;
		drift_fast_in <= 1'b1;
		acc(`RFS_A_FLAGS, 16'h0000, 1'b1);
		`CHK(q, 16'h0023)
		acc(`RFS_A_IRQMASK, 16'h0002, 1'b0);
		`CHK(irq_out, 1'b1)
		acc(`RFS_A_IRQMASK, 16'h0000, 1'b0);
		`CHK(irq_out, 1'b0)
		acc(`RFS_A_IRQMASK, 16'h0003, 1'b0);
		acc(`RFS_A_FLAGS, 16'h0003, 1'b0);
		`CHK(irq_out, 1'b0)
		acc(`RFS_A_FLAGS, 16'h0000, 1'b1);
		`CHK(q, 16'h0020)
		conclude();
	end
endmodule : test_rf_synth_divider_load_and_vco_cal
`default_nettype wire
